// File: ahbct_dev.sv
/*
  Device end of the generic host port: answers strobes, stretches
  cycles with the wait line, drives read data, hands accesses inward.
  Assumes the host end shares clk_i, so pins need no synchroniser.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ahbct_map.svh"

module ahbct_dev #(
  parameter ahbct_pkg::ahbct_addr_t MEM_BASE = `AHBCT_MEM_BASE
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // Port pins
  ahbct_if.dev                        bus,
  // Configuration straps
  input  wire logic                   cfg_direct_i,
  input  wire logic                   cfg_wait_i,
  // Inner access side
  output logic                        acc_o,
  output logic                        acc_we_o,
  output logic                        acc_mem_o,
  output ahbct_pkg::ahbct_addr_t      acc_addr_o,
  output ahbct_pkg::ahbct_data_t      acc_wdata_o,
  input  wire ahbct_pkg::ahbct_data_t rdata_i
);
  import ahbct_pkg::*;

  // ============================================================
  // Elaboration checks
  if (`AHBCT_WAIT_MEM_CYC > 15 || `AHBCT_RD_REG_CYC < 2) begin : g_chk
    $error("ahbct_dev: cycle counts out of range");
  end

  typedef struct packed {
    ahbct_dst_t  st;
    logic        is_wr;
    ahbct_cnt_t  cnt;
    ahbct_data_t wdat;
    logic        wait_n;
    logic        wait_oe;
    ahbct_data_t dout;
    logic        d_oe;
    logic        acc;
    logic        acc_we;
    logic        acc_mem;
    ahbct_addr_t acc_addr;
    ahbct_data_t acc_wdata;
  } ahbct_dstate_t;

  ahbct_dstate_t q;
  ahbct_dstate_t d;
  logic          strobe_lo;
  logic          mem_sel;

  // ============================================================
  // Next state
  always_comb begin
    strobe_lo = !bus.cs_n && (!bus.rd_n || !bus.wr_n);
    mem_sel   = ahbct_is_mem(cfg_direct_i, bus.addr, MEM_BASE);
    d         = q;
    d.acc     = 1'b0;
    d.wdat    = bus.data_lvl;  // Last byte seen before the write strobe rises
    case (q.st)
      DS_IDLE: begin
        if (strobe_lo) begin
          d.st       = DS_ACT;
          d.is_wr    = !bus.wr_n;
          d.acc_mem  = mem_sel;
          d.acc_addr = bus.addr;
          d.wait_oe  = cfg_wait_i;
          d.wait_n   = 1'b0;
          // Budget differs: with wait it bounds the stretch, without
          // it bounds the read data delay from the strobe edge
          if (cfg_wait_i) begin
            // Only display memory reads get the long stretch
            d.cnt = (mem_sel && bus.wr_n) ? ahbct_cnt_t'(`AHBCT_WAIT_MEM_CYC)
                                          : ahbct_cnt_t'(`AHBCT_WAIT_REG_CYC);
          end else begin
            d.cnt = mem_sel ? ahbct_cnt_t'(`AHBCT_RD_MEM_CYC - 1)
                            : ahbct_cnt_t'(`AHBCT_RD_REG_CYC - 1);
          end
          if (bus.wr_n) begin
            d.d_oe   = 1'b1;
            d.acc    = 1'b1;
            d.acc_we = 1'b0;
          end
        end
      end
      DS_ACT: begin
        if (q.cnt <= 4'h1) begin
          d.st     = DS_HOLD;
          d.wait_n = 1'b1;
          if (!q.is_wr) begin
            d.dout = rdata_i;
          end
        end else begin
          d.cnt = ahbct_cnt_t'(q.cnt - 4'h1);
        end
      end
      DS_HOLD: begin
        d.wait_n = 1'b1;
      end
      default: begin
        d.st = DS_IDLE;
      end
    endcase
    // Strobe back high: float the lines and commit a pending write;
    // an early rise cuts the stretch short rather than hang the port
    if (q.st != DS_IDLE && !strobe_lo) begin
      d.st      = DS_IDLE;
      d.wait_oe = 1'b0;
      d.wait_n  = 1'b1;
      d.d_oe    = 1'b0;
      if (q.is_wr) begin
        d.acc       = 1'b1;
        d.acc_we    = 1'b1;
        d.acc_wdata = q.wdat;
      end
    end
    if (!nrst_i) begin
      d        = '0;
      d.st     = DS_IDLE;
      d.wait_n = 1'b1;
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // Pins and inner side straight from the register
  assign bus.wait_n   = q.wait_n;
  assign bus.wait_oe  = q.wait_oe;
  assign bus.dev_d    = q.dout;
  assign bus.dev_d_oe = q.d_oe;
  assign acc_o        = q.acc;
  assign acc_we_o     = q.acc_we;
  assign acc_mem_o    = q.acc_mem;
  assign acc_addr_o   = q.acc_addr;
  assign acc_wdata_o  = q.acc_wdata;

endmodule : ahbct_dev

`default_nettype wire

// File: ahbct_host.sv
/*
  Host end of the generic host port: turns one request at a time into
  a read or write cycle, keeping strobe widths, gaps and cycle times.
  Assumes the device end shares clk_i, so pins need no synchroniser,
  and that both ends are strapped to the same mode.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ahbct_map.svh"

module ahbct_host #(
  parameter ahbct_pkg::ahbct_addr_t MEM_BASE = `AHBCT_MEM_BASE
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // Port pins
  ahbct_if.host                       bus,
  // Configuration straps
  input  wire logic                   cfg_direct_i,
  input  wire logic                   cfg_wait_i,
  // Request side
  input  wire logic                   req_valid_i,
  output logic                        req_ready_o,
  input  wire logic                   req_we_i,
  input  wire ahbct_pkg::ahbct_addr_t req_addr_i,
  input  wire ahbct_pkg::ahbct_data_t req_wdata_i,
  // Answer side
  output logic                        rsp_valid_o,
  output ahbct_pkg::ahbct_data_t      rsp_rdata_o
);
  import ahbct_pkg::*;

  // ============================================================
  // Elaboration checks
  if (`AHBCT_CYC_MEM_CYC > 14 || `AHBCT_ACT_MEM_CYC > 14) begin : g_chk_cnt
    $error("ahbct_host: cycle counts do not fit the counters");
  end
  if (`AHBCT_GAP_DWW_CYC > 14) begin : g_chk_gap
    $error("ahbct_host: gap count does not fit the counters");
  end

  // ============================================================
  // State
  typedef struct packed {
    ahbct_hst_t  st;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    ahbct_addr_t addr;
    ahbct_data_t dout;
    logic        d_oe;
    logic        we;
    logic        mem;
    logic        last_we;
    logic        last_mem;
    ahbct_cnt_t  cnt;
    ahbct_cnt_t  gap;
    ahbct_cnt_t  since_fall;
    logic        ready;
    logic        rsp_v;
    ahbct_data_t rsp_d;
  } ahbct_hstate_t;

  ahbct_hstate_t q;
  ahbct_hstate_t d;
  ahbct_cnt_t    gap_need;
  ahbct_cnt_t    cyc_need;
  ahbct_cnt_t    act_need;
  logic          may_start;
  logic          may_end;

  // ============================================================
  // Spacing and width figures for the current cycle
  always_comb begin
    gap_need = ahbct_gap_cyc(cfg_direct_i, cfg_wait_i, q.last_we, q.we);
    // Full cycle time only limits indirect mode without wait
    if (!cfg_direct_i && !cfg_wait_i) begin
      cyc_need = q.last_mem && !q.last_we ? ahbct_cnt_t'(`AHBCT_CYC_MEM_CYC)
                                          : ahbct_cnt_t'(`AHBCT_CYC_REG_CYC);
    end else begin
      cyc_need = 4'h0;
    end
    act_need = (q.mem && !q.we) ? ahbct_cnt_t'(`AHBCT_ACT_MEM_CYC)
                                : ahbct_cnt_t'(`AHBCT_ACT_REG_CYC);
    // Counters hold the edges already past, hence the plus one
    // One bit wider so a saturated counter cannot wrap to zero
    may_start = (({1'b0, q.gap} + 5'h01) >= {1'b0, gap_need}) &&
                (({1'b0, q.since_fall} + 5'h01) >= {1'b0, cyc_need});
    if (cfg_wait_i) begin
      // The wait line floats high until the device has answered, so
      // its level is only trusted after the first sampled edge
      may_end = (q.cnt >= ahbct_cnt_t'(`AHBCT_WAIT_SEEN_CYC)) && bus.wait_lvl;
    end else begin
      may_end = ahbct_cnt_t'(q.cnt + 4'h1) >= act_need;
    end
  end

  // ============================================================
  // Next state
  always_comb begin
    d            = q;
    d.rsp_v      = 1'b0;
    d.gap        = (q.rd_n && q.wr_n) ? ahbct_inc(q.gap) : 4'h0;
    d.since_fall = ahbct_inc(q.since_fall);
    case (q.st)
      HS_IDLE: begin
        // Ready comes up one cycle after reset or after a cycle ends
        d.ready = 1'b1;
        if (req_valid_i && q.ready) begin
          d.st    = HS_SETUP;
          d.ready = 1'b0;
          d.cs_n  = 1'b0;
          d.addr  = req_addr_i;
          d.we    = req_we_i;
          d.mem   = ahbct_is_mem(cfg_direct_i, req_addr_i, MEM_BASE);
          d.dout  = req_wdata_i;
          d.d_oe  = req_we_i;  // Data settles during the setup cycle
        end
      end
      HS_SETUP: begin
        // Address and select are already out; wait for spacing
        if (may_start) begin
          d.st         = HS_STROBE;
          d.rd_n       = q.we;
          d.wr_n       = !q.we;
          d.cnt        = 4'h0;
          d.since_fall = 4'h0;
        end
      end
      HS_STROBE: begin
        d.cnt = ahbct_inc(q.cnt);
        if (may_end) begin
          d.st       = HS_RECOV;
          d.rd_n     = 1'b1;
          d.wr_n     = 1'b1;
          d.gap      = 4'h0;
          d.last_we  = q.we;
          d.last_mem = q.mem;
          if (!q.we) begin
            d.rsp_v = 1'b1;
            d.rsp_d = bus.data_lvl;
          end
        end
      end
      HS_RECOV: begin
        // Select, address and write data held one cycle past the rise
        d.st    = HS_IDLE;
        d.cs_n  = 1'b1;
        d.d_oe  = 1'b0;
        d.ready = 1'b1;
      end
      default: begin
        d.st = HS_IDLE;
      end
    endcase
    if (!nrst_i) begin
      d            = '0;
      d.st         = HS_IDLE;
      d.cs_n       = 1'b1;
      d.rd_n       = 1'b1;
      d.wr_n       = 1'b1;
      d.gap        = `AHBCT_CNT_MAX;
      d.since_fall = `AHBCT_CNT_MAX;
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // ============================================================
  // Pins and request side straight from the register
  assign bus.cs_n      = q.cs_n;
  assign bus.rd_n      = q.rd_n;
  assign bus.wr_n      = q.wr_n;
  assign bus.addr      = q.addr;
  assign bus.host_d    = q.dout;
  assign bus.host_d_oe = q.d_oe;
  assign req_ready_o   = q.ready;
  assign rsp_valid_o   = q.rsp_v;
  assign rsp_rdata_o   = q.rsp_d;

endmodule : ahbct_host

`default_nettype wire

// File: ahbct_if.sv
/*
  Pins of the byte-wide generic host port, one modport per end.
  Assumes both ends run on the same system clock; the shared lines
  are resolved here, with a pull-up on data and on the wait line.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ahbct_map.svh"

interface ahbct_if;
  // ============================================================
  // Host driven
  logic                  cs_n;
  logic                  rd_n;
  logic                  wr_n;
  ahbct_pkg::ahbct_addr_t addr;
  ahbct_pkg::ahbct_data_t host_d;
  logic                  host_d_oe;
  // ============================================================
  // Device driven
  ahbct_pkg::ahbct_data_t dev_d;
  logic                  dev_d_oe;
  logic                  wait_n;
  logic                  wait_oe;
  // ============================================================
  // Resolved wire levels; an undriven line floats high
  ahbct_pkg::ahbct_data_t data_lvl;
  logic                  wait_lvl;

  assign data_lvl = host_d_oe ? host_d : (dev_d_oe ? dev_d : `AHBCT_BUS_IDLE);
  assign wait_lvl = wait_oe ? wait_n : 1'b1;

  modport dev  (input cs_n, rd_n, wr_n, addr, data_lvl,
                output dev_d, dev_d_oe, wait_n, wait_oe);
  modport host (output cs_n, rd_n, wr_n, addr, host_d, host_d_oe,
                input data_lvl, wait_lvl);
endinterface : ahbct_if

`default_nettype wire

// File: ahbct_map.svh
/*
  Constants of the byte-wide generic host port: clock period, timing
  figures in ns and the cycle counts derived from them, decode bounds.
  Assumes a single system clock shared by both ends of the port.
*/
`ifndef AHBCT_MAP_SVH
`define AHBCT_MAP_SVH

// ============================================================
// Clock
`define AHBCT_SYSCLK_PERIOD_NS 40
`define AHBCT_CYC_CEIL(ns)  (((ns) + `AHBCT_SYSCLK_PERIOD_NS - 1) / `AHBCT_SYSCLK_PERIOD_NS)
`define AHBCT_CYC_FLOOR(ns) ((ns) / `AHBCT_SYSCLK_PERIOD_NS)

// ============================================================
// Device side limits (longest times, rounded down)
`define AHBCT_WAIT_REG_MAX_NS  (2 * `AHBCT_SYSCLK_PERIOD_NS)
`define AHBCT_WAIT_MEM_MAX_NS  (7 * `AHBCT_SYSCLK_PERIOD_NS)
`define AHBCT_RD_REG_NOWAIT_NS (2 * `AHBCT_SYSCLK_PERIOD_NS + 19)
`define AHBCT_RD_MEM_NOWAIT_NS (6 * `AHBCT_SYSCLK_PERIOD_NS + 19)
`define AHBCT_WAIT_REG_CYC     `AHBCT_CYC_FLOOR(`AHBCT_WAIT_REG_MAX_NS)
`define AHBCT_WAIT_MEM_CYC     `AHBCT_CYC_FLOOR(`AHBCT_WAIT_MEM_MAX_NS)
`define AHBCT_RD_REG_CYC       `AHBCT_CYC_FLOOR(`AHBCT_RD_REG_NOWAIT_NS)
`define AHBCT_RD_MEM_CYC       `AHBCT_CYC_FLOOR(`AHBCT_RD_MEM_NOWAIT_NS)

// ============================================================
// Host side limits (least times, rounded up)
`define AHBCT_ACT_REG_NS  (3 * `AHBCT_SYSCLK_PERIOD_NS)
`define AHBCT_ACT_MEM_NS  (6 * `AHBCT_SYSCLK_PERIOD_NS + 10)
`define AHBCT_CYC_REG_NS  (4 * `AHBCT_SYSCLK_PERIOD_NS + 1)
`define AHBCT_CYC_MEM_NS  (7 * `AHBCT_SYSCLK_PERIOD_NS + 11)
`define AHBCT_GAP_WR_NS   (2 * `AHBCT_SYSCLK_PERIOD_NS)
`define AHBCT_GAP_DWW_NS  (4 * `AHBCT_SYSCLK_PERIOD_NS)
`define AHBCT_GAP_RD_NS   (1 * `AHBCT_SYSCLK_PERIOD_NS + 1)
`define AHBCT_ACT_REG_CYC `AHBCT_CYC_CEIL(`AHBCT_ACT_REG_NS)
`define AHBCT_ACT_MEM_CYC `AHBCT_CYC_CEIL(`AHBCT_ACT_MEM_NS)
`define AHBCT_CYC_REG_CYC `AHBCT_CYC_CEIL(`AHBCT_CYC_REG_NS)
`define AHBCT_CYC_MEM_CYC `AHBCT_CYC_CEIL(`AHBCT_CYC_MEM_NS)
`define AHBCT_GAP_WR_CYC  `AHBCT_CYC_CEIL(`AHBCT_GAP_WR_NS)
`define AHBCT_GAP_DWW_CYC `AHBCT_CYC_CEIL(`AHBCT_GAP_DWW_NS)
`define AHBCT_GAP_RD_CYC  `AHBCT_CYC_CEIL(`AHBCT_GAP_RD_NS)
`define AHBCT_WAIT_SEEN_CYC 1

// ============================================================
// Decode and widths
`define AHBCT_MEM_BASE 16'h0100
`define AHBCT_CMD_A0   1'b1
`define AHBCT_CNT_MAX  4'hF
`define AHBCT_BUS_IDLE 8'hFF

`endif

// File: ahbct_pkg.sv
/*
  Types and shared decode functions of the generic host port.
  Assumes ahbct_map.svh is on the include path.
*/
`include "ahbct_map.svh"

package ahbct_pkg;

  // ============================================================
  // Basic types
  typedef logic [15:0] ahbct_addr_t;
  typedef logic [7:0]  ahbct_data_t;
  typedef logic [3:0]  ahbct_cnt_t;

  typedef enum logic [1:0] {DS_IDLE, DS_ACT, DS_HOLD} ahbct_dst_t;
  typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_RECOV} ahbct_hst_t;

  // ============================================================
  // Decode: one address bit indirect, full address direct
  function automatic logic ahbct_is_mem(input logic        direct,
                                        input ahbct_addr_t addr,
                                        input ahbct_addr_t mem_base);
    if (direct) begin
      return addr >= mem_base;
    end
    return addr[0] != `AHBCT_CMD_A0;
  endfunction : ahbct_is_mem

  // Least strobe inactive time before the next cycle, in cycles
  function automatic ahbct_cnt_t ahbct_gap_cyc(input logic direct,
                                               input logic wait_en,
                                               input logic last_we,
                                               input logic we);
    if (!we) begin
      return ahbct_cnt_t'(`AHBCT_GAP_RD_CYC);
    end
    if (direct && wait_en && last_we) begin
      return ahbct_cnt_t'(`AHBCT_GAP_DWW_CYC);
    end
    return ahbct_cnt_t'(`AHBCT_GAP_WR_CYC);
  endfunction : ahbct_gap_cyc

  // Saturating increment for the small counters
  function automatic ahbct_cnt_t ahbct_inc(input ahbct_cnt_t c);
    return (c == `AHBCT_CNT_MAX) ? c : ahbct_cnt_t'(c + 4'h1);
  endfunction : ahbct_inc

endpackage : ahbct_pkg

// File: ahbct_sva.sv
/*
  Checker of the generic host port pins, with design code at both ends.
  Assumes one shared clock and equal straps on the two ends.
*/
`timescale 1ns/1ns
`default_nettype none

module ahbct_sva #(
  parameter ahbct_pkg::ahbct_addr_t MEM_BASE = 16'h0100
) (
  // Clock, reset and straps
  input wire logic                   clk_i,
  input wire logic                   nrst_i,
  input wire logic                   cfg_direct_i,
  input wire logic                   cfg_wait_i,
  // Host driven pins
  input wire logic                   cs_n,
  input wire logic                   rd_n,
  input wire logic                   wr_n,
  input wire ahbct_pkg::ahbct_addr_t addr,
  input wire ahbct_pkg::ahbct_data_t host_d,
  input wire logic                   host_d_oe,
  // Device driven pins
  input wire ahbct_pkg::ahbct_data_t dev_d,
  input wire logic                   dev_d_oe,
  input wire logic                   wait_n,
  input wire logic                   wait_oe,
  input wire logic                   wait_lvl
);
  import ahbct_pkg::*;

  // ============================================================
  // Helpers
  logic       strb;
  logic       mem;
  logic       strb_p;
  logic       last_we_q;
  logic       last_mr_q;
  ahbct_cnt_t gap_q;
  ahbct_cnt_t act_q;
  ahbct_cnt_t cyc_q;

  function automatic ahbct_cnt_t sat(input ahbct_cnt_t c);
    return (c == 4'hF) ? c : ahbct_cnt_t'(c + 4'h1);
  endfunction : sat

  // A cycle is live while select and either strobe are low
  assign strb = !cs_n && (!rd_n || !wr_n);
  assign mem  = cfg_direct_i ? (addr >= MEM_BASE) : (addr[0] == 1'b0);

  // Lengths in clocks; gap and cycle start saturated so the first cycle is not flagged
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      strb_p    <= 1'b0;
      last_we_q <= 1'b0;
      last_mr_q <= 1'b0;
      gap_q     <= 4'hF;
      act_q     <= 4'h0;
      cyc_q     <= 4'hF;
    end else begin
      strb_p <= strb;
      gap_q  <= strb ? 4'h0 : sat(gap_q);
      act_q  <= strb ? sat(act_q) : 4'h0;
      cyc_q  <= (strb && !strb_p) ? 4'h1 : sat(cyc_q);
      if (strb && !strb_p) begin
        last_we_q <= !wr_n;
        last_mr_q <= !rd_n && mem;
      end
    end
  end

  // ============================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_WAIT_DRIVE: assert property (cfg_wait_i && strb && !strb_p |=> wait_oe && !wait_n)
    else $error("wait not driven low after strobe");
  AST_WAIT_FLOAT: assert property (cfg_wait_i && !strb && strb_p |=> !wait_oe)
    else $error("wait not floated after strobe");
  AST_WAIT_SHORT: assert property (cfg_wait_i && $fell(wait_lvl) && !(!rd_n && mem)
    |-> !wait_lvl [*2] ##1 wait_lvl) else $error("short wait too long");
  AST_WAIT_LONG: assert property (cfg_wait_i && $fell(wait_lvl) && !rd_n && mem
    |-> !wait_lvl [*7] ##1 wait_lvl) else $error("memory read wait too long");
  AST_RD_AT_WAIT: assert property ($rose(wait_lvl) && strb && !rd_n
    |-> dev_d_oe ##1 (dev_d_oe && $stable(dev_d))) else $error("read data late");
  AST_HOLD_LOW: assert property (cfg_wait_i && strb && !wait_lvl |=> strb)
    else $error("strobe ended while wait low");
  AST_WR_SETUP: assert property ($rose(wr_n)
    |-> $past(host_d_oe, 2) && $past(host_d) == $past(host_d, 2))
    else $error("write data not stable before strobe end");
  AST_DRV_IN_READ: assert property (dev_d_oe |-> !rd_n || !$past(rd_n))
    else $error("device drives data outside read");
  AST_DRV_RELEASE: assert property ($rose(rd_n) |=> !dev_d_oe)
    else $error("device holds data after read");
  AST_GAP: assert property (strb && !strb_p
    |-> gap_q >= ((cfg_direct_i && cfg_wait_i && last_we_q && !wr_n) ? 4'h4 : 4'h2))
    else $error("strobe inactive time too short");
  AST_ACT_MIN: assert property (!cfg_wait_i && !strb && strb_p
    |-> act_q >= (last_mr_q ? 4'h7 : 4'h3)) else $error("strobe active time too short");
  AST_CYC_MIN: assert property (!cfg_wait_i && !cfg_direct_i && strb && !strb_p
    |-> cyc_q >= (last_mr_q ? 4'h8 : 4'h5)) else $error("cycle time too short");
  AST_RD_NOWAIT: assert property (!cfg_wait_i && strb && !strb_p && !rd_n && !mem
    |-> ##2 dev_d_oe ##1 (dev_d_oe && $stable(dev_d))) else $error("register data late");
endmodule : ahbct_sva

`default_nettype wire

// File: tb_top.sv
/*
  Self-checking bench: host and device ends joined by the interface,
  run through all four strap modes.
  Assumes design files and checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import ahbct_pkg::*;

  // ============================================================
  // Signals
  localparam ahbct_addr_t MEM_BASE = 16'h0100;
  logic        clk;
  logic        nrst;
  logic        direct;
  logic        wt;
  logic        req_valid;
  logic        req_ready;
  logic        req_we;
  ahbct_addr_t req_addr;
  ahbct_data_t req_wdata;
  logic        rsp_valid;
  ahbct_data_t rsp_rdata;
  logic        acc;
  logic        acc_we;
  logic        acc_mem;
  ahbct_addr_t acc_addr;
  ahbct_data_t acc_wdata;
  ahbct_data_t rdata;
  logic        strb;
  logic        strb_p;
  logic        seen_we;
  logic        seen_mem;
  ahbct_data_t seen_wd;
  ahbct_addr_t seen_addr;
  int          act_cnt;
  int          gap_cnt;
  int          wl_cnt;
  int          act_seen;
  int          gap_seen;
  int          wl_seen;
  int          n_errors;
  int          n_compared;

  ahbct_if bus_if ();

  ahbct_host #(.MEM_BASE(MEM_BASE)) ahbct_host_inst (
    .clk_i(clk), .nrst_i(nrst), .bus(bus_if), .cfg_direct_i(direct), .cfg_wait_i(wt),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_we_i(req_we),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rsp_rdata));

  ahbct_dev #(.MEM_BASE(MEM_BASE)) ahbct_dev_inst (
    .clk_i(clk), .nrst_i(nrst), .bus(bus_if), .cfg_direct_i(direct), .cfg_wait_i(wt),
    .acc_o(acc), .acc_we_o(acc_we), .acc_mem_o(acc_mem), .acc_addr_o(acc_addr),
    .acc_wdata_o(acc_wdata), .rdata_i(rdata));

  ahbct_sva #(.MEM_BASE(MEM_BASE)) ahbct_sva_inst (
    .clk_i(clk), .nrst_i(nrst), .cfg_direct_i(direct), .cfg_wait_i(wt),
    .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .addr(bus_if.addr),
    .host_d(bus_if.host_d), .host_d_oe(bus_if.host_d_oe), .dev_d(bus_if.dev_d),
    .dev_d_oe(bus_if.dev_d_oe), .wait_n(bus_if.wait_n), .wait_oe(bus_if.wait_oe),
    .wait_lvl(bus_if.wait_lvl));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Inner side answers from the address lines, which hold for the whole cycle
  always @(posedge clk) begin
    rdata <= bus_if.addr[7:0] ^ 8'h5A;
  end

  // Pin monitor: strobe lengths, wait lengths and the last inner access
  assign strb = !bus_if.cs_n && (!bus_if.rd_n || !bus_if.wr_n);
  always @(posedge clk) begin
    strb_p  <= strb;
    act_cnt <= strb ? act_cnt + 1 : 0;
    gap_cnt <= strb ? 0 : gap_cnt + 1;
    wl_cnt  <= (bus_if.wait_lvl === 1'b0) ? wl_cnt + 1 : 0;
    if (strb && !strb_p) gap_seen <= gap_cnt;
    if (!strb && strb_p) act_seen <= act_cnt;
    if (bus_if.wait_lvl === 1'b1 && wl_cnt != 0) wl_seen <= wl_cnt;
    if (acc === 1'b1) begin
      seen_we  <= acc_we;
      seen_mem <= acc_mem;
      seen_wd  <= acc_wdata;
      seen_addr <= acc_addr;
    end
  end

  // ============================================================
  // Common tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // Waits for ready, catching a read answer on the way; bounded
  task automatic wait_idle(output ahbct_data_t rd);
    int n;
    n = 0;
    rd = 'x;
    do begin
      @(posedge clk);
      if (rsp_valid === 1'b1) rd = rsp_rdata;
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_errors++;
      finish_test();
    end
  endtask : wait_idle

  task automatic host_req(input logic we, input ahbct_addr_t a, input ahbct_data_t wd,
                          output ahbct_data_t rd);
    wait_idle(rd);
    req_valid <= 1'b1;
    req_we    <= we;
    req_addr  <= a;
    req_wdata <= wd;
    @(posedge clk);
    req_valid <= 1'b0;
    wait_idle(rd);
    // Let the pin monitor's updates of this edge settle before judging
    @(negedge clk);
  endtask : host_req

  function automatic logic is_mem(input ahbct_addr_t a);
    return direct ? (a >= 16'h0100) : !a[0];
  endfunction : is_mem

  // ============================================================
  // Scenarios
  task automatic sc_reset(input logic d, input logic w);
    @(posedge clk);
    nrst   <= 1'b0;
    direct <= d;
    wt     <= w;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    check("wait idle", bus_if.wait_lvl, 1'b1);
    check("data idle", bus_if.data_lvl, 8'hFF);
  endtask : sc_reset

  task automatic sc_write(input ahbct_addr_t a, input ahbct_data_t d);
    ahbct_data_t rd;
    host_req(1'b1, a, d, rd);
    check("write kind", seen_we, 1'b1);
    check("write addr", seen_addr, a);
    check("write class", seen_mem, is_mem(a));
    check("write data", seen_wd, d);
    check("wait float", bus_if.wait_oe, 1'b0);
    if (wt) check("write wait", wl_seen, 2);
    else check("write width", act_seen >= 3, 1'b1);
  endtask : sc_write

  task automatic sc_read(input ahbct_addr_t a);
    ahbct_data_t rd;
    host_req(1'b0, a, 8'h00, rd);
    check("read data", rd, a[7:0] ^ 8'h5A);
    check("read class", seen_mem, is_mem(a));
    check("read addr", seen_addr, a);
    check("data released", bus_if.dev_d_oe, 1'b0);
    if (wt) check("read wait", wl_seen, is_mem(a) ? 7 : 2);
    else check("read width", act_seen >= (is_mem(a) ? 7 : 3), 1'b1);
  endtask : sc_read

  // Two writes back to back, then a read straight after a write
  task automatic sc_back_to_back(input ahbct_addr_t a);
    ahbct_data_t rd;
    host_req(1'b1, a, 8'h11, rd);
    host_req(1'b1, a, 8'hEE, rd);
    check("write gap", gap_seen >= ((direct && wt) ? 4 : 2), 1'b1);
    check("second write", seen_wd, 8'hEE);
    host_req(1'b0, a, 8'h00, rd);
    check("read gap", gap_seen >= 2, 1'b1);
    check("read after write", rd, a[7:0] ^ 8'h5A);
  endtask : sc_back_to_back

  initial begin
    nrst       = 1'b0;
    direct     = 1'b0;
    wt         = 1'b0;
    req_valid  = 1'b0;
    req_we     = 1'b0;
    req_addr   = 16'h0000;
    req_wdata  = 8'h00;
    n_errors   = 0;
    n_compared = 0;
    for (int m = 0; m < 4; m++) begin
      sc_reset(m[1], m[0]);
      sc_write(m[1] ? 16'h00FF : 16'h0001, 8'hC3);
      sc_read(m[1] ? 16'h00FF : 16'h0001);
      sc_write(m[1] ? 16'h0100 : 16'h0002, 8'h3C);
      sc_read(m[1] ? 16'h0100 : 16'h0002);
      sc_back_to_back(m[1] ? 16'h0234 : 16'h0000);
    end
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
